// ==== core_model.sv ====
// behavioural core: instruction boundary flag and return from service
// assumes the bench raises stall to model a slow core
`timescale 1ns/1ps
`default_nettype none
module core_model #(parameter int RET_DELAY = 30) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_take,
    input wire logic stall,
    output logic core_ready,
    output logic return_from_irq_instr
);
    int cnt;
    // a stalled core never reaches a boundary, so no vector is taken
    assign core_ready = !stall;
    // fixed routine length, then one return pulse brings enable back
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            return_from_irq_instr <= 1'b0;
        end else begin
            return_from_irq_instr <= (cnt == 1);
            if (irq_take) cnt <= RET_DELAY;
            else if (cnt != 0) cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// ==== interrupt_request_and_edge_ctrl.v ====
// interrupt request flags, enables, edge select, stack and dispatch
// assumes an AHB-Lite master on hclk and a core that takes vectors
// only at instruction boundaries flagged by core_ready
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"

module interrupt_request_and_edge_ctrl (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire ext_line_a,
    input wire ext_line_b,
    input wire power_down,
    input wire [5:0] periph_event_a,
    input wire [4:0] periph_event_b,
    input wire low_voltage_flag_low,
    input wire low_voltage_flag_high,
    input wire core_ready,
    input wire return_from_irq_instr,
    output reg irq_take,
    output reg [7:0] irq_vector,
    output reg save_context,
    output reg restore_context
);

    // edge test shared by both external lines
    function edge_hit;
        input [1:0] sel;
        input prev;
        input cur;
        begin
            case (sel)
                `EDGE_RISE: edge_hit = !prev && cur;
                `EDGE_FALL: edge_hit = prev && !cur;
                `EDGE_BOTH: edge_hit = prev ^ cur;
                default: edge_hit = 1'b0;
            endcase
        end
    endfunction

    // register index decode from a byte address
    function [7:0] reg_index;
        input [31:0] addr;
        begin
            reg_index = addr[9:2];
        end
    endfunction

    reg [7:0] irq_flags_a;
    reg [4:0] irq_flags_b;
    reg [7:0] enable_a;
    reg [4:0] enable_b;
    reg [3:0] ext_edge_select;
    reg global_irq_enable;
    reg [2:0] stack_pointer_bits;
    reg [1:0] wake_latch;

    reg [1:0] sync_a;
    reg [1:0] sync_b;
    reg [1:0] prev_line;

    reg wr_pend;
    reg [7:0] wr_index;
    reg rd_pend;
    reg [7:0] rd_index;

    wire addr_phase;
    wire [1:0] edge_now;
    wire [1:0] edge_take;
    wire [12:0] pending;
    wire dispatch;
    wire wr_flags_a;
    wire wr_flags_b;
    wire wr_stack;

    reg [7:0] next_vector;
    reg [7:0] read_mux;

    // writes never stall; a read waits one cycle so the data comes
    // from a flop after any write just before it has landed
    assign hreadyout = !rd_pend;
    assign hresp = 1'b0;
    assign addr_phase = hsel && hready && htrans[1];

    // address phase capture
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_index <= 8'h00;
            rd_pend <= 1'b0;
            rd_index <= 8'h00;
        end else begin
            wr_pend <= addr_phase && hwrite;
            rd_pend <= addr_phase && !hwrite;
            if (addr_phase) begin
                wr_index <= reg_index(haddr);
                rd_index <= reg_index(haddr);
            end
        end
    end

    assign wr_flags_a = wr_pend && (wr_index == `IDX_FLAGS_A);
    assign wr_flags_b = wr_pend && (wr_index == `IDX_FLAGS_B);
    assign wr_stack = wr_pend && (wr_index == `IDX_STACK);

    // two-flop pin synchronisers, then a third flop for the old level
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= 2'b00;
            sync_b <= 2'b00;
            prev_line <= 2'b00;
        end else begin
            sync_a <= {sync_a[0], ext_line_a};
            sync_b <= {sync_b[0], ext_line_b};
            prev_line <= {sync_b[1], sync_a[1]};
        end
    end

    // reserved select code yields no edge
    assign edge_now[0] = edge_hit(ext_edge_select[1:0],
        prev_line[0], sync_a[1]);
    assign edge_now[1] = edge_hit(ext_edge_select[3:2],
        prev_line[1], sync_b[1]);
    // line edges count only while that line is enabled
    assign edge_take = edge_now & enable_a[1:0];

    // request flags; a set in the cycle of a software clear wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_flags_a <= `RST_FLAGS;
            irq_flags_b <= 5'h00;
        end else begin
            irq_flags_a <= (wr_flags_a ? hwdata[7:0] : irq_flags_a)
                | {periph_event_a, edge_take};
            irq_flags_b <= (wr_flags_b ? hwdata[4:0] : irq_flags_b)
                | periph_event_b;
        end
    end

    // enables and edge select, software only
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_a <= 8'h00;
            enable_b <= 5'h00;
            ext_edge_select <= `RST_EDGE_SEL;
        end else if (wr_pend) begin
            if (wr_index == `IDX_ENABLE_A)
                enable_a <= hwdata[7:0];
            if (wr_index == `IDX_ENABLE_B)
                enable_b <= hwdata[4:0];
            if (wr_index == `IDX_EDGE_SEL)
                ext_edge_select <= hwdata[3:0];
        end
    end

    // wake latch: a matching edge while powered down is held until
    // that line has been dispatched, so it goes ahead of all unlatched sources
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_latch <= 2'b00;
        end else begin
            if (dispatch && next_vector == `VEC_LINE_A)
                wake_latch[0] <= 1'b0;
            if (dispatch && next_vector == `VEC_LINE_B)
                wake_latch[1] <= 1'b0;
            if (power_down) begin
                if (edge_take[0])
                    wake_latch[0] <= 1'b1;
                if (edge_take[1])
                    wake_latch[1] <= 1'b1;
            end
        end
    end

    // a source may go only when its flag and its enable are both set
    assign pending = {irq_flags_b & enable_b,
        irq_flags_a & enable_a};

    // vector pick: wake latch first, then the lowest vector
    always @* begin
        next_vector = `VEC_WAKEUP;
        if (wake_latch[0] && pending[0])
            next_vector = `VEC_LINE_A;
        else if (wake_latch[1] && pending[1])
            next_vector = `VEC_LINE_B;
        else if (pending[8])
            next_vector = `VEC_WAKEUP;
        else if (pending[0])
            next_vector = `VEC_LINE_A;
        else if (pending[1])
            next_vector = `VEC_LINE_B;
        else if (pending[2])
            next_vector = `VEC_BASIC_TIMER;
        else if (pending[3])
            next_vector = `VEC_TC_A;
        else if (pending[4])
            next_vector = `VEC_TC_B;
        else if (pending[5])
            next_vector = `VEC_TC_C;
        else if (pending[6])
            next_vector = `VEC_CAPTURE;
        else if (pending[7])
            next_vector = `VEC_ADC;
        else if (pending[9])
            next_vector = `VEC_SERIAL;
        else if (pending[10])
            next_vector = `VEC_UART_RX;
        else if (pending[11])
            next_vector = `VEC_UART_TX;
        else if (pending[12])
            next_vector = `VEC_MGMT;
    end

    // no entry while the core is returning, so the two never collide
    assign dispatch = global_irq_enable && core_ready
        && !return_from_irq_instr && (|pending);

    // stack register; hardware entry and return override a bus write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_irq_enable <= 1'b0;
            stack_pointer_bits <= `RST_STACK_PTR;
        end else if (dispatch) begin
            global_irq_enable <= 1'b0;
            stack_pointer_bits <= stack_pointer_bits - 3'h1;
        end else if (return_from_irq_instr) begin
            global_irq_enable <= 1'b1;
            stack_pointer_bits <= stack_pointer_bits + 3'h1;
        end else if (wr_stack) begin
            global_irq_enable <= hwdata[`GIE_BIT];
            stack_pointer_bits <= hwdata[2:0];
        end
    end

    // core handoff; flags are left set for software to clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_take <= 1'b0;
            irq_vector <= 8'h00;
            save_context <= 1'b0;
            restore_context <= 1'b0;
        end else begin
            irq_take <= dispatch;
            save_context <= dispatch;
            restore_context <= return_from_irq_instr;
            if (dispatch)
                irq_vector <= next_vector;
        end
    end

    // read data view of every register; unmapped reads as zero
    always @* begin
        case (rd_index)
            `IDX_FLAGS_A: read_mux = irq_flags_a;
            `IDX_FLAGS_B: read_mux = {3'h0, irq_flags_b};
            `IDX_ENABLE_A: read_mux = enable_a;
            `IDX_ENABLE_B: read_mux = {3'h0, enable_b};
            `IDX_EDGE_SEL: read_mux = {4'h0, ext_edge_select};
            `IDX_STACK: read_mux = {global_irq_enable,
                low_voltage_flag_low, low_voltage_flag_high,
                2'h0, stack_pointer_bits};
            default: read_mux = 8'h00;
        endcase
    end

    // read data loads in the wait cycle and holds until the next read
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (rd_pend)
            hrdata <= {24'h000000, read_mux};
    end

endmodule
`default_nettype wire

// ==== irq_ctrl_properties.sv ====
// assertion checker on the interrupt controller ports
// assumes one hclk domain and the register header on the include path
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic core_ready,
    input wire logic return_from_irq_instr,
    input wire logic irq_take,
    input wire logic [7:0] irq_vector,
    input wire logic save_context,
    input wire logic restore_context
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // address phase taken
    wire logic go = hsel && hready && htrans[1];
    a_take_saves: assert property (irq_take == save_context)
        else $error("save not paired with take");
    a_ret_restores: assert property (return_from_irq_instr |=> restore_context)
        else $error("no restore after return");
    a_restore_cause: assert property (restore_context |-> $past(return_from_irq_instr))
        else $error("restore without return");
    a_take_gap: assert property (irq_take |=> !irq_take)
        else $error("dispatch while enable cleared");
    a_vec_range: assert property (irq_take |-> irq_vector inside {[8'h08:8'h14]})
        else $error("vector out of range");
    a_vec_hold: assert property (!irq_take |-> $stable(irq_vector))
        else $error("vector moved without take");
    a_take_cause: assert property (irq_take |-> $past(core_ready && !return_from_irq_instr))
        else $error("take without ready core");
    a_read_wait: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (go && hwrite |=> hreadyout)
        else $error("write stalled");
    c_take: cover property (irq_take);
    c_ret: cover property (restore_context);
    c_read: cover property (go && !hwrite);
endmodule
bind interrupt_request_and_edge_ctrl irq_ctrl_checker irq_ctrl_checker_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .core_ready(core_ready),
    .return_from_irq_instr(return_from_irq_instr), .irq_take(irq_take),
    .irq_vector(irq_vector), .save_context(save_context), .restore_context(restore_context));
`default_nettype wire

// ==== irq_ctrl_regs.vh ====
// register offsets, field positions, reset values and vectors
// assumes a word-wide register bus, each register index times four
// What this block does
// - every peripheral source event sets its own request flag
// - flag register A: 8 rw bits, reset zero, lines, timers, converter
// - flag register B: wakeup, serial, uart rx, uart tx, management; 7:5 zero
// - nothing is dispatched unless global enable, bit 7, is one
// - accepted request loads its vector and deepens the stack one level
// - external line edges set the flag only while its enable is one
// - line A vectors to 0x09, line B to 0x0A
// - edge matching the select during power-down is latched, served first
// - 2-bit edge selects: 01 rise, 10 fall, 11 both; reset 10
// - basic timer overflow sets its flag regardless of its enable
// - disabled basic timer still flags but never vectors
// - basic timer vectors to 0x0B
// - stack register: global enable bit 7, pointer bits 2:0 reset 111
// - entry clears global enable, return sets it again
// - context saved in the same cycle as the vector take, restored on return
// - dispatch needs both enable and flag; enable blocks only the line A and B flags
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// register indices; byte address is four times the index
`define IDX_FLAGS_A 8'h97
`define IDX_FLAGS_B 8'h98
`define IDX_ENABLE_A 8'h9A
`define IDX_ENABLE_B 8'h9B
`define IDX_EDGE_SEL 8'h9F
`define IDX_STACK 8'hEF

`define RST_FLAGS 8'h00
`define RST_EDGE_SEL 4'hA
`define RST_STACK_PTR 3'h7
`define FLAGS_B_MASK 8'h1F
`define EDGE_SEL_MASK 8'h0F

// edge select codes
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

`define GIE_BIT 7
`define LVD_LOW_BIT 6
`define LVD_HIGH_BIT 5

// vectors, one per source, in flag order except wakeup at 0x08
`define VEC_LINE_A 8'h09
`define VEC_LINE_B 8'h0A
`define VEC_BASIC_TIMER 8'h0B
`define VEC_TC_A 8'h0C
`define VEC_TC_B 8'h0D
`define VEC_TC_C 8'h0E
`define VEC_CAPTURE 8'h0F
`define VEC_ADC 8'h10
`define VEC_SERIAL 8'h11
`define VEC_UART_RX 8'h12
`define VEC_UART_TX 8'h13
`define VEC_MGMT 8'h14
`define VEC_WAKEUP 8'h08

`endif

// ==== tb_interrupt_request_and_edge_ctrl.sv ====
// self-checking bench: bus tasks, event pulses, pin edges, dispatch
// assumes the core model answers every take with a later return
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.vh"
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_interrupt_request_and_edge_ctrl;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pa = 1, pb = 1, stall = 0, pd = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0] htrans = 0;
    logic [5:0] ea = 0;
    logic [4:0] eb = 0;
    logic [7:0] d;
    wire logic hreadyout, hresp, irq_take, save_context, restore_context, rdy, ret;
    wire logic [31:0] hrdata;
    wire logic [7:0] irq_vector;
    int num_errors = 0, samples_checked = 0, cycles = 0, takes = 0;
    initial forever #10 hclk = ~hclk;
    interrupt_request_and_edge_ctrl interrupt_request_and_edge_ctrl_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ext_line_a(pa), .ext_line_b(pb),
        .power_down(pd), .periph_event_a(ea), .periph_event_b(eb),
        .low_voltage_flag_low(1'b1), .low_voltage_flag_high(1'b0), .core_ready(rdy),
        .return_from_irq_instr(ret), .irq_take(irq_take), .irq_vector(irq_vector),
        .save_context(save_context), .restore_context(restore_context));
    core_model core_model_i (.hclk(hclk), .hresetn(hresetn), .irq_take(irq_take),
        .stall(stall), .core_ready(rdy), .return_from_irq_instr(ret));
    // one single transfer; address held until hready, then data phase
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] wd);
        @(posedge hclk);
        hsel <= 1;
        haddr <= {22'h0, i, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        bus(1'b1, i, v);
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        `CHECK(hresp, 1'b0)
        `CHECK(d, e)
    endtask
    // bounded wait for the dispatch pulse, then its vector
    task automatic wait_take(input logic [7:0] v);
        int n;
        n = 0;
        do begin @(posedge hclk); #1; n++; end while (irq_take !== 1'b1 && n < 200);
        // a wait that runs out counts as a mismatch, not a stale vector
        `CHECK(irq_take, 1'b1)
        `CHECK(irq_vector, v)
    endtask
    task automatic pins(input logic a, input logic b);
        @(posedge hclk);
        pa <= a;
        pb <= b;
        repeat (6) @(posedge hclk);
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // dispatch counter and hang guard
    always @(posedge hclk) begin
        cycles++;
        if (irq_take === 1'b1) takes++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1;
        rdc(`IDX_FLAGS_A, 8'h00);
        rdc(`IDX_FLAGS_B, 8'h00);
        rdc(`IDX_EDGE_SEL, 8'h0A);
        rdc(`IDX_STACK, 8'h47);
        rdc(8'h00, 8'h00);
        // every peripheral source pulses once with all enables off
        @(posedge hclk);
        ea <= 6'h3F;
        eb <= 5'h1F;
        @(posedge hclk);
        ea <= 0;
        eb <= 0;
        repeat (20) @(posedge hclk);
        rdc(`IDX_FLAGS_A, 8'hFC);
        rdc(`IDX_FLAGS_B, 8'h1F);
        `CHECK(takes, 0)
        wr(`IDX_FLAGS_A, 8'h00);
        wr(`IDX_FLAGS_B, 8'hE0);
        rdc(`IDX_FLAGS_B, 8'h00);
        pins(1'b0, 1'b1);
        rdc(`IDX_FLAGS_A, 8'h00);
        wr(`IDX_ENABLE_A, 8'h07);
        pins(1'b1, 1'b1);
        rdc(`IDX_FLAGS_A, 8'h00);
        pins(1'b0, 1'b1);
        rdc(`IDX_FLAGS_A, 8'h01);
        // line A reserved, line B both edges
        wr(`IDX_FLAGS_A, 8'h00);
        wr(`IDX_EDGE_SEL, 8'h0C);
        pins(1'b1, 1'b0);
        rdc(`IDX_FLAGS_A, 8'h02);
        @(posedge hclk);
        ea <= 6'h01;
        @(posedge hclk);
        ea <= 0;
        // slow core first; both pending, lower vector must win
        stall <= 1;
        wr(`IDX_STACK, 8'h87);
        repeat (10) @(posedge hclk);
        `CHECK(takes, 0)
        @(posedge hclk);
        stall <= 0;
        wait_take(`VEC_LINE_B);
        rdc(`IDX_STACK, 8'h46);
        wr(`IDX_FLAGS_A, 8'h04);
        wait_take(`VEC_BASIC_TIMER);
        wr(`IDX_FLAGS_A, 8'h00);
        repeat (40) @(posedge hclk);
        rdc(`IDX_STACK, 8'hC7);
        wr(`IDX_EDGE_SEL, 8'h02);
        @(posedge hclk);
        pa <= 0;
        wait_take(`VEC_LINE_A);
        wr(`IDX_FLAGS_A, 8'h00);
        repeat (40) @(posedge hclk);
        `CHECK(takes, 3)
        // powered down with wakeup pending: latched line B must go ahead of it
        wr(`IDX_ENABLE_B, 8'h01);
        wr(`IDX_EDGE_SEL, 8'h06);
        @(posedge hclk);
        stall <= 1;
        pd <= 1;
        eb <= 5'h01;
        @(posedge hclk);
        eb <= 0;
        pins(1'b0, 1'b1);
        @(posedge hclk);
        pd <= 0;
        stall <= 0;
        wait_take(`VEC_LINE_B);
        wr(`IDX_FLAGS_A, 8'h00);
        wait_take(`VEC_WAKEUP);
        wr(`IDX_FLAGS_B, 8'h00);
        repeat (40) @(posedge hclk);
        `CHECK(takes, 5)
        finish_test();
    end
endmodule
`default_nettype wire
